// file: opmode_pkg.sv
// Package for the operating-mode controller: register map, field layout, modes, timing.
// Assumes a 32-bit Avalon-MM register bus, one byte-wide register per aligned word.
package opmode_pkg;

	localparam logic [7:0] STOP_CTRL_OFFSET = 8'h38;
	localparam logic [7:0] CLK_CTRL_OFFSET = 8'h3C;
	localparam logic [7:0] TB_CTRL_OFFSET = 8'h40;
	localparam logic [7:0] MODE_STAT_OFFSET = 8'h44;

	localparam logic [7:0] STOP_CTRL_RESET = 8'h00;
	localparam logic [7:0] CLK_CTRL_RESET = 8'hC0;
	localparam logic [7:0] TB_CTRL_RESET = 8'h00;

	// Stop control register fields
	localparam int STOP_START_BIT = 7;
	localparam int RELEASE_METHOD_BIT = 6;
	localparam int POST_STOP_BIT = 5;
	localparam int PORT_OUTPUT_BIT = 4;
	localparam int WARMUP_LSB = 2;

	// Clock control register fields
	localparam int FAST_OSC_BIT = 7;
	localparam int SLOW_OSC_BIT = 6;
	localparam int MAIN_CLK_BIT = 5;
	localparam int IDLE_BIT = 4;
	localparam int TG_HALT_BIT = 2;

	// Timebase control register fields
	localparam int TB_ENABLE_BIT = 7;
	localparam int MASTER_IE_BIT = 6;
	localparam int TB_IE_BIT = 5;
	localparam int TB_LATCH_BIT = 4;
	localparam int TB_CLK_LSB = 0;

	// Warm-up counts in oscillator cycles
	localparam logic [17:0] WARM_FAST_00 = 18'h30000;
	localparam logic [17:0] WARM_FAST_01 = 18'h10000;
	localparam logic [17:0] WARM_FAST_10 = 18'h0C000;
	localparam logic [17:0] WARM_FAST_11 = 18'h04000;
	localparam logic [17:0] WARM_SLOW_00 = 18'h06000;
	localparam logic [17:0] WARM_SLOW_01 = 18'h02000;
	localparam logic [17:0] WARM_SLOW_10 = 18'h000C0;
	localparam logic [17:0] WARM_SLOW_11 = 18'h00040;

	typedef enum logic [3:0] {
		FAST_SINGLE_RUN = 4'h0,
		FAST_DUAL_RUN = 4'h1,
		SLOW_DUAL_RUN = 4'h3,
		SLOW_ONLY_RUN = 4'h2,
		SLOW_ONLY_IDLE = 4'h6,
		SLOW_DUAL_IDLE = 4'h7,
		FAST_DUAL_IDLE = 4'h5,
		SLOW_TIMEBASE_HALT = 4'h4,
		STOP_HALT = 4'hC,
		STOP_WARMUP = 4'hD
	} op_mode_e;

	typedef struct packed {
		logic stop_start;
		logic release_level;
		logic post_stop_slow;
		logic port_keep;
		logic [1:0] warmup_select;
	} stop_ctrl_s;

	typedef struct packed {
		logic fast_osc_enable;
		logic slow_osc_enable;
		logic main_clock_select;
		logic idle;
		logic timing_gen_halt;
	} clk_ctrl_s;

	typedef struct packed {
		logic timebase_enable;
		logic master_interrupt_enable;
		logic timebase_irq_enable;
		logic timebase_interrupt_latch;
		logic [1:0] timebase_clock_select;
	} tb_ctrl_s;

	typedef struct packed {
		logic fast_osc_on;
		logic slow_osc_on;
		logic cpu_run;
		logic cpu_on_slow;
		logic periph_run;
		logic divider_low_run;
		logic port_drive;
		logic stop_pin_hiz;
		logic timebase_irq;
		logic mode_reset;
	} clk_out_s;

endpackage

// file: operating_mode_controller.sv
// Operating-mode controller: dual-clock run/idle/sleep modes, stop with warm-up.
// Assumes synchronous inputs, Avalon-MM slave with fixed one wait state, wake events as pulses.
// Operation
// R1: Main-clock select written 1 in fast dual run enters slow dual run.
// R2: Main-clock select written 0 in slow dual run returns to fast dual run.
// R3: Fast oscillator enable cleared in slow dual run enters slow-only run; set returns.
// R4: Software never clears the slow oscillator enable in slow dual run.
// R5: Slow-only run has fast oscillator off, core and peripherals on slow clock.
// R6: Slow-only run and slow idle modes stop divider stages one to six.
// R7: Fast dual idle halts CPU, keeps oscillators and peripherals; wake returns fast dual.
// R8: Slow-only idle halts CPU and fast oscillator; wake returns slow-only run.
// R9: Slow dual idle is like slow-only idle but keeps the fast oscillator.
// R10: Timing-generator halt set in slow run enters timebase-only halt.
// R11: Timebase source falling edge ends the halt into slow-only run.
// R12: Halt entered with timebase enabled sets the timebase latch; service needs three enables.
// R13: Stop-start bit 1 stops oscillators and halts all activity, state kept.
// R14: Stop pin releases stop by level or edge, then warm-up, then resume.
// R15: Release method 0 selects edge release, 1 selects level release.
// R16: Post-stop field 0 returns to fast run, 1 to slow-only run.
// R17: Port output field 0 floats ports in stop, 1 keeps latched outputs.
// R18: Two-bit warm-up field selects one of four fast or slow warm-up counts.
// R19: Software sets post-stop field to match the run speed before stop.
// R20: Stop ended by reset always returns to fast single run.
// R21: Bits 1 and 0 of the stop control register read undefined.
// R22: Stop pin goes high impedance on stop entry, whatever the port field.
// R23: Leaving the timebase halt clears the timing-generator halt bit.
// R24: Illegal oscillator enable combinations force a reset.
// R25: Warm-up holds CPU and peripherals halted until the selected count is reached.
// R26: Mode held in one encoded register, changed only by writes, wakes, timebase source falls, stop pin release, warm-up end and reset.
`timescale 1ns/1ps

module operating_mode_controller #(
	parameter int WARM_W = 18
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic dual_clock_mode,
	input wire logic wake_event,
	input wire logic stop_pin_in,
	input wire logic fast_tick,
	input wire logic slow_tick,
	input wire logic [3:0] timebase_sources,
	output opmode_pkg::clk_out_s clk_out,
	output opmode_pkg::op_mode_e mode
);

	initial begin
		if (WARM_W < 18) begin
			$error("WARM_W too narrow for warm-up counts");
		end
	end

	typedef struct packed {
		opmode_pkg::op_mode_e mode;
		opmode_pkg::stop_ctrl_s stop;
		opmode_pkg::clk_ctrl_s clk;
		opmode_pkg::tb_ctrl_s tb;
		logic tb_armed;
		logic [WARM_W-1:0] warm_cnt;
		logic [WARM_W-1:0] warm_target;
		logic warm_slow;
		logic stop_pin_d;
		logic [3:0] tb_src_d;
		logic ack;
		logic [31:0] rdata;
		opmode_pkg::clk_out_s out;
	} state_s;

	state_s st_r;
	state_s st_nxt;

	function automatic logic [WARM_W-1:0] warm_count(input logic slow, input logic [1:0] sel);
		logic [17:0] c;
		c = 18'h00000;
		case ({slow, sel})
			3'h0: c = opmode_pkg::WARM_FAST_00;
			3'h1: c = opmode_pkg::WARM_FAST_01;
			3'h2: c = opmode_pkg::WARM_FAST_10;
			3'h3: c = opmode_pkg::WARM_FAST_11;
			3'h4: c = opmode_pkg::WARM_SLOW_00;
			3'h5: c = opmode_pkg::WARM_SLOW_01;
			3'h6: c = opmode_pkg::WARM_SLOW_10;
			default: c = opmode_pkg::WARM_SLOW_11;
		endcase
		return WARM_W'(c);
	endfunction

	function automatic logic is_slow(input opmode_pkg::op_mode_e m);
		return (m == opmode_pkg::SLOW_DUAL_RUN) || (m == opmode_pkg::SLOW_ONLY_RUN);
	endfunction

	logic wr_stop;
	logic wr_clk;
	logic wr_tb;
	logic rd_any;
	logic tb_fall;
	logic pin_rise;
	logic [7:0] wbyte;
	opmode_pkg::clk_ctrl_s clk_w;

	assign wbyte = avs_writedata[7:0];
	assign rd_any = avs_read && !st_r.ack;
	assign wr_stop = avs_write && !st_r.ack && avs_byteenable[0] && avs_address == opmode_pkg::STOP_CTRL_OFFSET;
	assign wr_clk = avs_write && !st_r.ack && avs_byteenable[0] && avs_address == opmode_pkg::CLK_CTRL_OFFSET;
	assign wr_tb = avs_write && !st_r.ack && avs_byteenable[0] && avs_address == opmode_pkg::TB_CTRL_OFFSET;
	assign tb_fall = st_r.tb_src_d[st_r.tb.timebase_clock_select] && !timebase_sources[st_r.tb.timebase_clock_select];
	assign pin_rise = stop_pin_in && !st_r.stop_pin_d;
	assign clk_w = '{fast_osc_enable: wbyte[opmode_pkg::FAST_OSC_BIT], slow_osc_enable: wbyte[opmode_pkg::SLOW_OSC_BIT],
		main_clock_select: wbyte[opmode_pkg::MAIN_CLK_BIT], idle: wbyte[opmode_pkg::IDLE_BIT],
		timing_gen_halt: wbyte[opmode_pkg::TG_HALT_BIT]};

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic illegal;
		logic rel;
		illegal = 1'b0;
		rel = 1'b0;
		st_nxt = st_r;
		st_nxt.stop_pin_d = stop_pin_in;
		st_nxt.tb_src_d = timebase_sources;
		// One wait state on every access, then ack
		st_nxt.ack = (avs_read || avs_write) && !st_r.ack;
		st_nxt.rdata = 32'h00000000;

		if (wr_stop) begin
			st_nxt.stop = '{stop_start: wbyte[opmode_pkg::STOP_START_BIT],
				release_level: wbyte[opmode_pkg::RELEASE_METHOD_BIT],
				post_stop_slow: wbyte[opmode_pkg::POST_STOP_BIT],
				port_keep: wbyte[opmode_pkg::PORT_OUTPUT_BIT],
				warmup_select: wbyte[opmode_pkg::WARMUP_LSB +: 2]};
		end
		if (wr_tb) begin
			st_nxt.tb.timebase_enable = wbyte[opmode_pkg::TB_ENABLE_BIT];
			st_nxt.tb.master_interrupt_enable = wbyte[opmode_pkg::MASTER_IE_BIT];
			st_nxt.tb.timebase_irq_enable = wbyte[opmode_pkg::TB_IE_BIT];
			st_nxt.tb.timebase_clock_select = wbyte[opmode_pkg::TB_CLK_LSB +: 2];
			// Writing 1 clears the latch
			if (wbyte[opmode_pkg::TB_LATCH_BIT]) begin
				st_nxt.tb.timebase_interrupt_latch = 1'b0;
			end
		end
		if (wr_clk) begin
			// R24 illegal enables
			illegal = (!clk_w.fast_osc_enable && !clk_w.slow_osc_enable) ||
				(!clk_w.fast_osc_enable && !clk_w.main_clock_select) ||
				(!clk_w.slow_osc_enable && clk_w.main_clock_select);
			st_nxt.clk = clk_w;
		end

		// R26 mode register
		case (st_r.mode)
			opmode_pkg::FAST_SINGLE_RUN, opmode_pkg::FAST_DUAL_RUN: begin
				if (wr_clk) begin
					// R1 switch to slow
					if (clk_w.main_clock_select && dual_clock_mode) begin
						st_nxt.mode = opmode_pkg::SLOW_DUAL_RUN;
					end else if (clk_w.idle && st_r.mode == opmode_pkg::FAST_DUAL_RUN) begin
						st_nxt.mode = opmode_pkg::FAST_DUAL_IDLE;
					end
				end
			end
			opmode_pkg::SLOW_DUAL_RUN: begin
				if (wr_clk) begin
					// R2 back to fast
					if (!clk_w.main_clock_select) begin
						st_nxt.mode = opmode_pkg::FAST_DUAL_RUN;
					// R3 fast oscillator off
					end else if (!clk_w.fast_osc_enable) begin
						st_nxt.mode = opmode_pkg::SLOW_ONLY_RUN;
					end else if (clk_w.idle) begin
						st_nxt.mode = opmode_pkg::SLOW_DUAL_IDLE;
					end else if (clk_w.timing_gen_halt) begin
						st_nxt.mode = opmode_pkg::SLOW_TIMEBASE_HALT;
					end
				end
			end
			opmode_pkg::SLOW_ONLY_RUN: begin
				if (wr_clk) begin
					// R3 fast oscillator back on
					if (clk_w.fast_osc_enable) begin
						st_nxt.mode = opmode_pkg::SLOW_DUAL_RUN;
					end else if (clk_w.idle) begin
						st_nxt.mode = opmode_pkg::SLOW_ONLY_IDLE;
					end else if (clk_w.timing_gen_halt) begin
						st_nxt.mode = opmode_pkg::SLOW_TIMEBASE_HALT;
					end
				end
			end
			opmode_pkg::FAST_DUAL_IDLE: begin
				// R7 wake to fast dual
				if (wake_event) begin
					st_nxt.mode = opmode_pkg::FAST_DUAL_RUN;
					st_nxt.clk.idle = 1'b0;
				end
			end
			opmode_pkg::SLOW_ONLY_IDLE: begin
				// R8 wake to slow-only
				if (wake_event) begin
					st_nxt.mode = opmode_pkg::SLOW_ONLY_RUN;
					st_nxt.clk.idle = 1'b0;
				end
			end
			opmode_pkg::SLOW_DUAL_IDLE: begin
				// R9 wake to slow dual
				if (wake_event) begin
					st_nxt.mode = opmode_pkg::SLOW_DUAL_RUN;
					st_nxt.clk.idle = 1'b0;
				end
			end
			opmode_pkg::SLOW_TIMEBASE_HALT: begin
				// R11 timebase edge resumes
				if (tb_fall) begin
					st_nxt.mode = opmode_pkg::SLOW_ONLY_RUN;
					// R23 halt bit self-clears
					st_nxt.clk.timing_gen_halt = 1'b0;
					st_nxt.clk.fast_osc_enable = 1'b0;
					// R12 latch after return
					if (st_r.tb_armed) begin
						st_nxt.tb.timebase_interrupt_latch = 1'b1;
					end
				end
			end
			opmode_pkg::STOP_HALT: begin
				// R14 R15 release criterion
				rel = st_r.stop.release_level ? stop_pin_in : pin_rise;
				if (rel) begin
					st_nxt.mode = opmode_pkg::STOP_WARMUP;
					st_nxt.warm_cnt = '0;
					// R18 warm-up count
					st_nxt.warm_target = warm_count(st_r.stop.post_stop_slow, st_r.stop.warmup_select);
					st_nxt.warm_slow = st_r.stop.post_stop_slow;
				end
			end
			opmode_pkg::STOP_WARMUP: begin
				// R25 hold until warm-up ends
				if ((st_r.warm_slow ? slow_tick : fast_tick) && st_r.warm_cnt != st_r.warm_target) begin
					st_nxt.warm_cnt = st_r.warm_cnt + 1'b1;
				end
				if (st_r.warm_cnt == st_r.warm_target) begin
					st_nxt.stop.stop_start = 1'b0;
					// R16 return mode
					if (st_r.warm_slow) begin
						st_nxt.mode = opmode_pkg::SLOW_ONLY_RUN;
						st_nxt.clk.fast_osc_enable = 1'b0;
						st_nxt.clk.main_clock_select = 1'b1;
					end else begin
						st_nxt.mode = dual_clock_mode ? opmode_pkg::FAST_DUAL_RUN : opmode_pkg::FAST_SINGLE_RUN;
						st_nxt.clk.fast_osc_enable = 1'b1;
						st_nxt.clk.main_clock_select = 1'b0;
					end
				end
			end
			default: st_nxt.mode = opmode_pkg::FAST_SINGLE_RUN;
		endcase

		// R10 timebase halt entry captures enable
		if (wr_clk && clk_w.timing_gen_halt && is_slow(st_r.mode)) begin
			st_nxt.tb_armed = st_r.tb.timebase_enable;
		end
		// R13 stop entry from any run mode
		if (wr_stop && wbyte[opmode_pkg::STOP_START_BIT] && st_r.mode inside {opmode_pkg::FAST_SINGLE_RUN,
			opmode_pkg::FAST_DUAL_RUN, opmode_pkg::SLOW_DUAL_RUN, opmode_pkg::SLOW_ONLY_RUN}) begin
			st_nxt.mode = opmode_pkg::STOP_HALT;
		end

		if (rd_any) begin
			case (avs_address)
				// R21 low bits read as zero here
				opmode_pkg::STOP_CTRL_OFFSET: st_nxt.rdata = {24'h000000, st_r.stop, 2'h0};
				opmode_pkg::CLK_CTRL_OFFSET: st_nxt.rdata = {24'h000000, st_r.clk.fast_osc_enable,
					st_r.clk.slow_osc_enable, is_slow(st_r.mode) || st_r.mode inside {opmode_pkg::SLOW_ONLY_IDLE,
					opmode_pkg::SLOW_DUAL_IDLE, opmode_pkg::SLOW_TIMEBASE_HALT}, st_r.clk.idle, 1'b0,
					st_r.clk.timing_gen_halt, 2'h0};
				opmode_pkg::TB_CTRL_OFFSET: st_nxt.rdata = {24'h000000, st_r.tb.timebase_enable,
					st_r.tb.master_interrupt_enable, st_r.tb.timebase_irq_enable,
					st_r.tb.timebase_interrupt_latch, 2'h0, st_r.tb.timebase_clock_select};
				opmode_pkg::MODE_STAT_OFFSET: st_nxt.rdata = {28'h0000000, st_nxt.mode};
				default: st_nxt.rdata = 32'h00000000;
			endcase
		end

		// Outputs decoded from the next mode so they leave flip-flops in step with it
		st_nxt.out.mode_reset = illegal;
		// R5 R8 fast oscillator off in slow-only modes
		st_nxt.out.fast_osc_on = !(st_nxt.mode inside {opmode_pkg::SLOW_ONLY_RUN, opmode_pkg::SLOW_ONLY_IDLE,
			opmode_pkg::STOP_HALT}) && !(st_nxt.mode == opmode_pkg::STOP_WARMUP && st_nxt.warm_slow);
		st_nxt.out.slow_osc_on = dual_clock_mode && st_nxt.mode != opmode_pkg::STOP_HALT;
		st_nxt.out.cpu_run = st_nxt.mode inside {opmode_pkg::FAST_SINGLE_RUN, opmode_pkg::FAST_DUAL_RUN,
			opmode_pkg::SLOW_DUAL_RUN, opmode_pkg::SLOW_ONLY_RUN};
		st_nxt.out.cpu_on_slow = is_slow(st_nxt.mode);
		st_nxt.out.periph_run = !(st_nxt.mode inside {opmode_pkg::SLOW_TIMEBASE_HALT, opmode_pkg::STOP_HALT,
			opmode_pkg::STOP_WARMUP});
		// R6 low divider stages static in slow-only run, slow idle modes and stop halt
		st_nxt.out.divider_low_run = !(st_nxt.mode inside {opmode_pkg::SLOW_ONLY_RUN, opmode_pkg::SLOW_ONLY_IDLE,
			opmode_pkg::SLOW_DUAL_IDLE, opmode_pkg::STOP_HALT});
		// R17 R22 port drive during stop
		st_nxt.out.port_drive = st_nxt.mode != opmode_pkg::STOP_HALT || st_nxt.stop.port_keep;
		st_nxt.out.stop_pin_hiz = st_nxt.mode == opmode_pkg::STOP_HALT;
		// R12 service needs all three enables
		st_nxt.out.timebase_irq = st_nxt.tb.timebase_interrupt_latch && st_nxt.tb.master_interrupt_enable &&
			st_nxt.tb.timebase_irq_enable && st_nxt.tb.timebase_enable;
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			// R20 reset always lands in fast single run
			st_r <= '{mode: opmode_pkg::FAST_SINGLE_RUN, stop: opmode_pkg::STOP_CTRL_RESET[7:2],
				clk: {opmode_pkg::CLK_CTRL_RESET[7:4], opmode_pkg::CLK_CTRL_RESET[2]},
				tb: '0, tb_armed: 1'b0, warm_cnt: '0, warm_target: '0, warm_slow: 1'b0,
				stop_pin_d: 1'b0, tb_src_d: 4'h0, ack: 1'b0, rdata: 32'h00000000,
				out: 10'h3C0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign avs_waitrequest = !st_r.ack;
	assign avs_readdata = st_r.rdata;
	assign clk_out = st_r.out;
	assign mode = st_r.mode;

	////////////////////////////////////////////////////////////////////////////////
	chk_slow_entry_write: assert property (@(posedge clock) disable iff (!arst_n) // R1
		(st_r.mode == opmode_pkg::FAST_DUAL_RUN && wr_clk && clk_w.main_clock_select && dual_clock_mode)
		|=> mode == opmode_pkg::SLOW_DUAL_RUN) else $error("slow dual run not entered");
	chk_fast_return_write: assert property (@(posedge clock) disable iff (!arst_n) // R2
		(mode == opmode_pkg::SLOW_DUAL_RUN && wr_clk && !clk_w.main_clock_select && !wr_stop)
		|=> mode == opmode_pkg::FAST_DUAL_RUN) else $error("fast dual run not restored");
	chk_slow_only_osc: assert property (@(posedge clock) disable iff (!arst_n) // R5
		mode == opmode_pkg::SLOW_ONLY_RUN |-> !clk_out.fast_osc_on && clk_out.cpu_on_slow)
		else $error("fast oscillator on in slow-only run");
	chk_divider_static: assert property (@(posedge clock) disable iff (!arst_n) // R6
		mode inside {opmode_pkg::SLOW_ONLY_IDLE, opmode_pkg::SLOW_DUAL_IDLE} |-> !clk_out.divider_low_run)
		else $error("low divider running in sleep");
	chk_halt_resume_edge: assert property (@(posedge clock) disable iff (!arst_n) // R11
		(mode == opmode_pkg::SLOW_TIMEBASE_HALT && tb_fall) |=> mode == opmode_pkg::SLOW_ONLY_RUN
		&& !st_r.clk.timing_gen_halt) else $error("timebase halt not released");
	chk_stop_halts_cpu: assert property (@(posedge clock) disable iff (!arst_n) // R13
		mode == opmode_pkg::STOP_HALT |-> !clk_out.cpu_run && !clk_out.periph_run && !clk_out.slow_osc_on)
		else $error("activity during stop");
	chk_stop_pin_float: assert property (@(posedge clock) disable iff (!arst_n) // R22
		mode == opmode_pkg::STOP_HALT |-> clk_out.stop_pin_hiz && (clk_out.port_drive == st_r.stop.port_keep))
		else $error("stop pin or ports wrong in stop");
	chk_warmup_hold: assert property (@(posedge clock) disable iff (!arst_n) // R25
		(mode == opmode_pkg::STOP_WARMUP && st_r.warm_cnt != st_r.warm_target) |=> mode == opmode_pkg::STOP_WARMUP)
		else $error("warm-up ended early");
	chk_illegal_reset: assert property (@(posedge clock) disable iff (!arst_n) // R24
		(wr_clk && ((!clk_w.fast_osc_enable && !clk_w.slow_osc_enable) || (!clk_w.fast_osc_enable &&
		!clk_w.main_clock_select) || (!clk_w.slow_osc_enable && clk_w.main_clock_select))) |=> clk_out.mode_reset)
		else $error("illegal enables gave no reset");

endmodule

// file: tb_top.sv
// Self-checking bench for the operating-mode controller: registers, run and idle modes, timebase halt, stop.
// Assumes the design package and an Avalon-MM register bus with waitrequest.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; $display("wrong value at %0t: %0h vs %0h", $time, (a), (b)); end end

module tb_top;
	logic clock = 1'h0;
	logic arst_n = 1'h0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic dual = 1'h0;
	logic wake = 1'h0;
	logic pin = 1'h0;
	logic [3:0] tb_src = 4'h0;
	opmode_pkg::clk_out_s clk_out;
	opmode_pkg::op_mode_e mode;
	int n_errors = 0;
	int n_tests = 0;
	int n_rst = 0;
	logic [31:0] rd;

	// Ticks held high: one oscillator cycle per clock keeps warm-up counts short
	operating_mode_controller u_dut (.clock(clock), .arst_n(arst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dual_clock_mode(dual),
		.wake_event(wake), .stop_pin_in(pin), .fast_tick(1'h1), .slow_tick(1'h1),
		.timebase_sources(tb_src), .clk_out(clk_out), .mode(mode));

	initial begin
		forever #20 clock = ~clock;
	end

	always @(posedge clock) begin
		if (clk_out.mode_reset === 1'h1) n_rst++;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Request held until the rising edge that samples waitrequest low; data taken and request dropped there
	task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
		int i;
		@(posedge clock);
		avs_address <= addr;
		avs_writedata <= {24'h0, wd};
		avs_write <= wr;
		avs_read <= !wr;
		for (i = 0; i < 20; i++) begin
			@(posedge clock);
			if (avs_waitrequest === 1'h0) break;
		end
		if (i == 20) begin
			n_errors++;
			summarize();
		end
		rd = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
	endtask

	task automatic wait_mode(input opmode_pkg::op_mode_e m, input int lim);
		int i;
		i = 0;
		do begin
			@(negedge clock);
			i++;
		end while (mode !== m && i < lim);
		`CHK(mode, m)
		if (mode !== m) summarize();
	endtask

	task automatic do_reset();
		arst_n <= 1'h0;
		repeat (3) @(posedge clock);
		arst_n <= 1'h1;
	endtask

	task automatic pulse_wake();
		@(posedge clock);
		wake <= 1'h1;
		@(posedge clock);
		wake <= 1'h0;
	endtask

	task automatic warm(input int lo, input opmode_pkg::op_mode_e m);
		int n;
		n = 0;
		wait_mode(opmode_pkg::STOP_WARMUP, 4);
		while (mode === opmode_pkg::STOP_WARMUP && n < lo + 8) begin
			@(negedge clock);
			n++;
			if (n == 10) `CHK(clk_out.cpu_run | clk_out.periph_run, 1'h0)
		end
		`CHK(n >= lo && n <= lo + 4, 1'h1)
		wait_mode(m, 4);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		`CHK(mode, opmode_pkg::FAST_SINGLE_RUN)
		bus(1'h0, opmode_pkg::STOP_CTRL_OFFSET, 8'h00);
		`CHK(rd, {24'h0, opmode_pkg::STOP_CTRL_RESET})
		bus(1'h1, opmode_pkg::STOP_CTRL_OFFSET, 8'h6F);
		bus(1'h0, opmode_pkg::STOP_CTRL_OFFSET, 8'h00);
		`CHK(rd, 32'h6C)
		bus(1'h1, 8'h50, 8'hFF);
		bus(1'h0, 8'h50, 8'h00);
		`CHK(rd, 32'h0)
		bus(1'h1, opmode_pkg::STOP_CTRL_OFFSET, 8'h00);
	endtask

	// Edge release entered with the pin already high must wait for a fresh rise
	task automatic t_stop_fast();
		@(posedge clock);
		pin <= 1'h1;
		bus(1'h1, opmode_pkg::STOP_CTRL_OFFSET, 8'h8C);
		wait_mode(opmode_pkg::STOP_HALT, 4);
		`CHK(clk_out.fast_osc_on | clk_out.cpu_run, 1'h0)
		`CHK(clk_out.port_drive, 1'h0)
		`CHK(clk_out.stop_pin_hiz, 1'h1)
		repeat (6) @(posedge clock);
		pin <= 1'h0;
		`CHK(mode, opmode_pkg::STOP_HALT)
		@(posedge clock);
		pin <= 1'h1;
		warm(16384, opmode_pkg::FAST_SINGLE_RUN);
		bus(1'h0, opmode_pkg::STOP_CTRL_OFFSET, 8'h00);
		`CHK(rd[opmode_pkg::STOP_START_BIT], 1'h0)
		pin <= 1'h0;
	endtask

	task automatic t_illegal();
		int base;
		base = n_rst;
		bus(1'h1, opmode_pkg::CLK_CTRL_OFFSET, 8'h40);
		repeat (3) @(posedge clock);
		`CHK(n_rst - base, 1)
	endtask

	task automatic t_dual();
		@(posedge clock);
		dual <= 1'h1;
		bus(1'h1, opmode_pkg::CLK_CTRL_OFFSET, 8'hE0);
		wait_mode(opmode_pkg::SLOW_DUAL_RUN, 4);
		bus(1'h1, opmode_pkg::CLK_CTRL_OFFSET, 8'hF0);
		wait_mode(opmode_pkg::SLOW_DUAL_IDLE, 4);
		`CHK({clk_out.fast_osc_on, clk_out.cpu_run, clk_out.divider_low_run}, 3'h4)
		pulse_wake();
		wait_mode(opmode_pkg::SLOW_DUAL_RUN, 4);
		bus(1'h1, opmode_pkg::CLK_CTRL_OFFSET, 8'hC0);
		wait_mode(opmode_pkg::FAST_DUAL_RUN, 4);
		bus(1'h1, opmode_pkg::CLK_CTRL_OFFSET, 8'hD0);
		wait_mode(opmode_pkg::FAST_DUAL_IDLE, 4);
		`CHK({clk_out.fast_osc_on, clk_out.slow_osc_on, clk_out.cpu_run, clk_out.periph_run}, 4'hD)
		pulse_wake();
		wait_mode(opmode_pkg::FAST_DUAL_RUN, 4);
		bus(1'h1, opmode_pkg::CLK_CTRL_OFFSET, 8'hE0);
		bus(1'h1, opmode_pkg::CLK_CTRL_OFFSET, 8'h60);
		wait_mode(opmode_pkg::SLOW_ONLY_RUN, 6);
		`CHK({clk_out.fast_osc_on, clk_out.cpu_on_slow, clk_out.periph_run}, 3'h3)
		`CHK(clk_out.divider_low_run, 1'h0)
		bus(1'h1, opmode_pkg::CLK_CTRL_OFFSET, 8'h70);
		wait_mode(opmode_pkg::SLOW_ONLY_IDLE, 4);
		`CHK({clk_out.fast_osc_on, clk_out.cpu_run, clk_out.periph_run, clk_out.divider_low_run}, 4'h2)
		pulse_wake();
		wait_mode(opmode_pkg::SLOW_ONLY_RUN, 4);
		bus(1'h1, opmode_pkg::CLK_CTRL_OFFSET, 8'hE0);
		wait_mode(opmode_pkg::SLOW_DUAL_RUN, 4);
		bus(1'h1, opmode_pkg::CLK_CTRL_OFFSET, 8'h60);
		wait_mode(opmode_pkg::SLOW_ONLY_RUN, 4);
	endtask

	// Source held high before entry so only the deliberate fall can end the halt
	task automatic t_timebase();
		@(posedge clock);
		tb_src <= 4'h1;
		bus(1'h1, opmode_pkg::TB_CTRL_OFFSET, 8'hE0);
		bus(1'h1, opmode_pkg::CLK_CTRL_OFFSET, 8'h64);
		wait_mode(opmode_pkg::SLOW_TIMEBASE_HALT, 4);
		`CHK({clk_out.slow_osc_on, clk_out.cpu_run, clk_out.periph_run}, 3'h4)
		repeat (4) @(posedge clock);
		`CHK(mode, opmode_pkg::SLOW_TIMEBASE_HALT)
		tb_src <= 4'h0;
		wait_mode(opmode_pkg::SLOW_ONLY_RUN, 6);
		`CHK(clk_out.periph_run, 1'h1)
		bus(1'h0, opmode_pkg::TB_CTRL_OFFSET, 8'h00);
		`CHK(rd[opmode_pkg::TB_LATCH_BIT], 1'h1)
		`CHK(clk_out.timebase_irq, 1'h1)
		bus(1'h1, opmode_pkg::TB_CTRL_OFFSET, 8'hA0);
		`CHK(clk_out.timebase_irq, 1'h0)
		bus(1'h0, opmode_pkg::CLK_CTRL_OFFSET, 8'h00);
		`CHK(rd[opmode_pkg::TG_HALT_BIT], 1'h0)
	endtask

	task automatic t_stop_slow();
		bus(1'h1, opmode_pkg::STOP_CTRL_OFFSET, 8'hF8);
		wait_mode(opmode_pkg::STOP_HALT, 4);
		`CHK({clk_out.slow_osc_on, clk_out.port_drive, clk_out.stop_pin_hiz}, 3'h3)
		@(posedge clock);
		pin <= 1'h1;
		warm(192, opmode_pkg::SLOW_ONLY_RUN);
		@(posedge clock);
		pin <= 1'h0;
	endtask

	task automatic t_stop_reset();
		bus(1'h1, opmode_pkg::STOP_CTRL_OFFSET, 8'hBC);
		wait_mode(opmode_pkg::STOP_HALT, 4);
		do_reset();
		repeat (2) @(posedge clock);
		`CHK(mode, opmode_pkg::FAST_SINGLE_RUN)
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		do_reset();
		t_regs();
		t_stop_fast();
		t_illegal();
		do_reset();
		t_dual();
		t_timebase();
		t_stop_slow();
		t_stop_reset();
		summarize();
	end
endmodule
